// ---- rtl/qdac_pkg.sv ----
/*
 * Package for the four-channel converter holding-register block: address
 * compare fields, channel decode, word layout and code constants.
 * Assumes a multiplexed 16-bit bus with its strobes sampled on clk.
 */
// How it works
// - Compare switches to address bits 3-11 under bank select
// - Closed switch reads zero; nine switches used
// - Address bits 1-2 pick one of four registers
// - Compare only when address bit 12 is one
// - Four contiguous words, base 170000 to 177770 octal
// - Bus initialise clears all four registers
// - Registers hold value until written
// - Offset binary: 0000 low, 4000 zero, 7777 high
// - All-ones code sits one step below full scale
// - Each register word or byte writable and readable
// - Fourth register bits 0-3 drive digital outputs
// - No control or status register at all
package qdac_pkg;
    localparam int DATA_W = 16;
    localparam int CODE_W = 12;
    localparam int NUM_CH = 4;
    localparam int SW_W = 10;
    localparam int CMP_LO = 3;
    localparam int CMP_HI = 11;
    localparam int CMP_W = CMP_HI - CMP_LO + 1;
    localparam int IOPAGE_BIT = 12;
    localparam int SEL_LO = 1;
    localparam int DOUT_W = 4;
    localparam int DOUT_CH = 3;
    localparam logic [CODE_W-1:0] CODE_RESET = 12'h000;
    localparam logic [CODE_W-1:0] CODE_MID = 12'h800;
    localparam logic [DATA_W-1:0] RD_IDLE = 16'h0000;

    typedef logic [CODE_W-1:0] qdac_code_t;
    typedef logic [1:0] qdac_sel_t;

    // Bus transfer carried as one bundle
    typedef struct packed {
        logic sync;
        logic bank7;
        logic wr_cmd;
        logic rd_cmd;
        logic byte_hi;
        logic byte_lo;
        logic [DATA_W-1:0] dal;
    } qdac_bus_t;

    typedef enum logic [1:0] {QDAC_IDLE, QDAC_CLAIMED, QDAC_IGNORED} qdac_state_t;
endpackage

// ---- rtl/qdac_hold_mem.sv ----
/*
 * Four-word holding store with byte-lane writes and registered read data.
 * Assumes writes arrive already decoded from the bus side.
 */
`timescale 1ns/1ps
module qdac_hold_mem
    import qdac_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Write and read
    input wire logic wr_lo,
    input wire logic wr_hi,
    input wire qdac_sel_t sel,
    input wire logic [DATA_W-1:0] wdata,
    output logic [CODE_W-1:0] rdata,
    // Held codes
    output qdac_code_t codes [NUM_CH]
);
    // Holding words; init comes in on rst
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_CH; i++) begin
                codes[i] <= CODE_RESET;
            end
        end else if (ce) begin
            if (wr_lo) begin
                codes[sel][7:0] <= wdata[7:0];
            end
            if (wr_hi) begin
                codes[sel][CODE_W-1:8] <= wdata[CODE_W-1:8];
            end
        end
    end

    // Read port registered so the bus sees a clean value
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= CODE_RESET;
        end else if (ce) begin
            rdata <= codes[sel];
        end
    end
endmodule // qdac_hold_mem

// ---- rtl/qdac_top.sv ----
/*
 * Bus-side control for a four-channel 12-bit converter card: address match
 * against a switch pack, register select, word/byte access, init clear.
 * Assumes bus strobes are synchronous to clk; bus_init is the reset.
 * Register codes go to converters untransformed; coding is software's job.
 * A transfer is one sync window: its first cycle carries the address, the
 * later cycles carry the command, the lanes and the data. The card answers
 * only in a window that it claimed in that window's first cycle.
 * Assumes the master holds its command until reply is seen.
 * Limitation: sync must drop for a cycle between windows; without that gap
 * the card sees one long window and handles every later command by the first window's claim and select.
 * Outputs all come from registers, so every answer lags its cause by at least one edge.
 */
`timescale 1ns/1ps
module qdac_top
    import qdac_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Switch pack, closed switch reads as zero
    input wire logic [SW_W-1:0] address_match_switch_pack,
    // Bus
    input wire qdac_bus_t bus,
    output logic [DATA_W-1:0] rd_data,
    output logic rd_oe,
    output logic reply,
    // Converter codes and digital port
    output qdac_code_t dac_code [NUM_CH],
    output logic [DOUT_W-1:0] dig_out
);
    // Clock enable low holds every register below, the store included; a
    // window that straddles a low stretch simply resumes where it stopped.
    // Bus init is asynchronous and wins over the enable.

    // Window tracking
    qdac_state_t state;
    qdac_state_t next_state;
    qdac_sel_t sel;
    qdac_sel_t next_sel;
    logic claimed;
    logic claimed_wr;
    logic wr_go;
    logic rd_go;

    // Store side
    logic [CODE_W-1:0] mem_rdata;
    qdac_code_t codes [NUM_CH];
    logic wr_lo;
    logic wr_hi;

    // Address match: nine compare bits plus I/O page and bank select
    function automatic logic addr_hit(input logic [DATA_W-1:0] a,
                                      input logic [SW_W-1:0] sw, input logic b7);
        addr_hit = b7 && a[IOPAGE_BIT]
                   && (a[CMP_HI:CMP_LO] == sw[CMP_W-1:0]);
    endfunction

    // Register select from the word address; bit 0 plays no part
    function automatic qdac_sel_t reg_select(input logic [DATA_W-1:0] a);
        reg_select = a[SEL_LO+1:SEL_LO];
    endfunction

    // Lane strobe: claimed window, write command, first cycle, lane on
    function automatic logic lane_write(input logic is_claimed, input logic wr,
                                        input logic done, input logic lane);
        lane_write = is_claimed && wr && !done && lane;
    endfunction

    // Read word: a code with bits 15-12 forced to zero
    function automatic logic [DATA_W-1:0] read_word(input qdac_code_t c);
        read_word = {{(DATA_W-CODE_W){1'b0}}, c};
    endfunction

    // Digital port bits: the low bits of a code
    function automatic logic [DOUT_W-1:0] port_bits(input qdac_code_t c);
        port_bits = c[DOUT_W-1:0];
    endfunction

    // Window states: idle waits for sync; claimed answers commands; ignored
    // rides out a window meant for another card. The address is looked at
    // in the idle state only, so a data word later in a missed window, which
    // may well look like our address, can never claim the card.
    always_comb begin
        next_state = state;
        next_sel = sel;
        case (state)
            QDAC_IDLE: begin
                if (bus.sync) begin
                    if (addr_hit(bus.dal, address_match_switch_pack, bus.bank7)) begin
                        next_state = QDAC_CLAIMED;
                        next_sel = reg_select(bus.dal);
                    end else begin
                        next_state = QDAC_IGNORED;
                    end
                end
            end
            QDAC_CLAIMED: begin
                if (!bus.sync) begin
                    next_state = QDAC_IDLE;
                end
            end
            QDAC_IGNORED: begin
                if (!bus.sync) begin
                    next_state = QDAC_IDLE;
                end
            end
            default: begin
                next_state = QDAC_IDLE;
            end
        endcase
    end

    // Window state; bus init drops any claim in flight
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= QDAC_IDLE;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // Select held for the whole window; a missed window leaves it alone,
    // so a read in a claimed window never sees a foreign select
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sel <= 2'h0;
        end else if (ce) begin
            sel <= next_sel;
        end
    end

    // Command qualifiers for the claimed window
    assign claimed = (state == QDAC_CLAIMED);
    assign wr_go = claimed && bus.wr_cmd;
    assign rd_go = claimed && bus.rd_cmd;

    // First write cycle seen; a master that holds its command for several
    // cycles still writes once, so a late change on the data lines is not
    // taken as a second write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            claimed_wr <= 1'b0;
        end else if (ce) begin
            claimed_wr <= wr_go;
        end
    end

    // Lane strobes; a byte write leaves the other lane as it was.
    // Both lanes together make a word write
    assign wr_lo = lane_write(claimed, bus.wr_cmd, claimed_wr, bus.byte_lo);
    assign wr_hi = lane_write(claimed, bus.wr_cmd, claimed_wr, bus.byte_hi);

    // Holding store; its words change only on a lane strobe or bus init, and a low
    // clock enable freezes them with everything else
    qdac_hold_mem u_mem (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .wr_lo(wr_lo),
        .wr_hi(wr_hi),
        .sel(sel),
        .wdata(bus.dal),
        .rdata(mem_rdata),
        .codes(codes)
    );

    // Drive enable follows a claimed read; there is no status register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_oe <= 1'b0;
        end else if (ce) begin
            rd_oe <= rd_go;
        end
    end

    // Read word, taken from the registered store copy; the copy follows
    // the select of the current window one edge after the claim
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data <= RD_IDLE;
        end else if (ce) begin
            rd_data <= read_word(mem_rdata);
        end
    end

    // Reply: a write is answered one cycle after its command; a read waits
    // until the drive enable has stood for a cycle, because the store copy
    // reaches rd_data only two edges after the claim. Trades one cycle of
    // read latency for never acknowledging stale data.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reply <= 1'b0;
        end else if (ce) begin
            reply <= wr_go || (rd_go && rd_oe);
        end
    end

    // Converter codes, registered; they pass untouched, mid code is zero volts.
    // A read never disturbs them
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_CH; i++) begin
                dac_code[i] <= CODE_RESET;
            end
        end else if (ce) begin
            dac_code <= codes;
        end
    end

    // Digital port; these bits also sit in the low end of channel 3's code,
    // so using them as control lines disturbs that converter by a few steps
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dig_out <= 4'h0;
        end else if (ce) begin
            dig_out <= port_bits(codes[DOUT_CH]);
        end
    end
endmodule // qdac_top

// ---- tb/qdac_sva.sv ----
/* Checker on qdac_top ports. Assumes its clk and rst. */
`timescale 1ns/1ps
module qdac_sva
    import qdac_pkg::*;
(
    // Top ports
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [SW_W-1:0] address_match_switch_pack,
    input wire qdac_bus_t bus,
    input wire logic [DATA_W-1:0] rd_data,
    input wire logic rd_oe,
    input wire logic reply,
    input wire qdac_code_t dac_code [NUM_CH],
    input wire logic [DOUT_W-1:0] dig_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Match terms and all codes in one word
    wire hit = bus.bank7 && bus.dal[12] && bus.dal[11:3] == address_match_switch_pack[8:0];
    wire [47:0] all = {dac_code[0], dac_code[1], dac_code[2], dac_code[3]};
    property p_in; disable iff (1'b0) rst |-> all == 0 && dig_out == 0; endproperty
    a_in: assert property (p_in) else $error("init");
    property p_do; dig_out == dac_code[3][3:0]; endproperty
    a_do: assert property (p_do) else $error("dout");
    property p_hi; rd_oe |-> rd_data[15:12] == 0; endproperty
    a_hi: assert property (p_hi) else $error("hi");
    property p_ms; $rose(bus.sync) && !hit |=> !reply [*4]; endproperty
    a_ms: assert property (p_ms) else $error("miss");
    property p_12; $rose(bus.sync) && !bus.dal[12] |=> !reply [*4]; endproperty
    a_12: assert property (p_12) else $error("b12");
    property p_cl; $rose(bus.sync) && hit && ce ##1 (bus.wr_cmd || bus.rd_cmd) && ce
        |-> ##[1:2] reply; endproperty
    a_cl: assert property (p_cl) else $error("claim");
    property p_hd; !bus.wr_cmd && !$past(bus.wr_cmd) && !$past(bus.wr_cmd, 2) |-> $stable(all);
    endproperty
    a_hd: assert property (p_hd) else $error("hold");
    property p_oe; bus.wr_cmd |-> !rd_oe; endproperty
    a_oe: assert property (p_oe) else $error("oe");
    property p_rd; reply && bus.rd_cmd |-> rd_oe; endproperty
    a_rd: assert property (p_rd) else $error("read reply without drive");
endmodule // qdac_sva
bind qdac_top qdac_sva chk (.clk, .rst, .ce, .address_match_switch_pack, .bus, .rd_data,
    .rd_oe, .reply, .dac_code, .dig_out);

// ---- tb/qdac_host.sv ----
/* Host bus master model. Assumes the top answers on reply. */
`timescale 1ns/1ps
module qdac_host
    import qdac_pkg::*;
(
    // Answer in, bus out
    input wire logic clk,
    input wire logic reply,
    input wire logic [DATA_W-1:0] rd_data,
    output qdac_bus_t bus
);
    initial bus = '0;
    // Hold until reply, for at most five edges; released lines show flipped data, not stale
    task automatic xfer(input logic wr, input logic [15:0] a, d, input logic [1:0] ln,
        output logic ack, output logic [15:0] q);
        @(negedge clk) bus <= '{1, a >= 16'he000, 0, 0, 0, 0, a};
        @(negedge clk) bus <= '{1, bus.bank7, wr, !wr, ln[1], ln[0], wr ? d : ~a};
        ack = 0;
        for (int i = 0; i < 5 && !ack; i++) @(posedge clk) {ack, q} = {reply, rd_data};
        @(negedge clk) bus <= '{0, 0, 0, 0, 0, 0, ~bus.dal};
    endtask
endmodule // qdac_host

// ---- tb/testbench.sv ----
/* Bench: corner and random writes, reads, refusals, resets. Assumes the package. */
`timescale 1ns/1ps
module testbench
    import qdac_pkg::*;
;
    logic clk = 0, rst = 0, ce = 1, ack, rd_oe, reply;
    logic [SW_W-1:0] sw = 10'h224;
    logic [15:0] q, d, rd_data;
    logic [15:0] cor [4] = '{16'h0000, 16'h0800, 16'hffff, 16'h87ff};
    logic [1:0] ln;
    qdac_bus_t bus;
    qdac_code_t dac_code [NUM_CH], ex [NUM_CH];
    logic [DOUT_W-1:0] dig_out;
    int num_errors = 0, total_checks = 0, seed = 32'hb147b825;
    always #50 clk = ~clk;
    qdac_top uut (.clk, .rst, .ce(ce), .address_match_switch_pack(sw), .bus, .rd_data,
        .rd_oe, .reply, .dac_code, .dig_out);
    qdac_host host (.clk, .reply, .rd_data, .bus);
    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, e);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %0t %h %h", $time, g, e);
        end
    endtask
    // A lost claim ends the run
    task automatic go(input logic wr, input logic [15:0] a, input logic e);
        host.xfer(wr, a, d, wr ? ln : 2'b00, ack, q);
        chk(16'(ack), 16'(e));
        if (ack !== e) end_of_test();
    endtask
    task automatic verify();
        for (int c = 0; c < NUM_CH; c++) begin
            go(0, {4'hf, sw[8:0], 2'(c), 1'b0}, 1);
            chk(q, 16'(ex[c]));
            chk(16'(dac_code[c]), 16'(ex[c]));
        end
        chk(16'(dig_out), 16'(ex[3][3:0]));
    endtask
    // Corners first, then random rounds
    initial begin
        rst = 1;
        ex = '{default: '0};
        repeat (20) @(negedge clk);
        rst = 0;
        verify();
        for (int n = 0; n < 12; n++) begin
            for (int c = 0; c < NUM_CH; c++) begin
                d = n ? 16'($random(seed)) : cor[c];
                ln = n ? 2'($random(seed)) : 2'b11;
                if (ln == 0) ln = 2'b10;
                go(1, {4'hf, sw[8:0], 2'(c), 1'b0}, 1);
                ex[c] = {ln[1] ? d[11:8] : ex[c][11:8], ln[0] ? d[7:0] : ex[c][7:0]};
            end
            verify();
            go(1, {4'he, sw[8:0], 3'h0}, 0);
            go(1, {4'hf, sw[8:0] ^ 9'(1 << ($unsigned(seed) % 9)), 3'h2}, 0);
            // Frozen enable: a matching write must go unanswered and unstored
            @(negedge clk) ce = 0;
            go(1, {4'hf, sw[8:0], 3'h4}, 0);
            ce = 1;
            verify();
            sw = 10'($random(seed));
        end
        rst = 1;
        @(negedge clk) rst = 0;
        ex = '{default: '0};
        verify();
        end_of_test();
    end
endmodule // testbench
